/* hw/lsmc_defines.svh */
/*
  constants of the light sensor main control block: bus address, register
  offsets, field positions, channel sets and software reset timing.
  assumes inclusion by bare name from the package and the test modules.
*/
`ifndef LSMC_DEFINES_SVH
`define LSMC_DEFINES_SVH

// 7-bit bus address, value arbitrary
`define LSMC_I2C_ADDR 7'h2A

`define LSMC_REG_STATUS0 8'h00
`define LSMC_REG_CTRL 8'h15
`define LSMC_CTRL_RESET 8'h00
`define LSMC_READ_ZERO 8'h00

`define LSMC_BIT_SRST 7
`define LSMC_BIT_SAI 3
`define LSMC_BIT_MODE 1
`define LSMC_BIT_EN 0

`define LSMC_ST_BIT_POR 7
`define LSMC_ST_BIT_LSINT 1

// channel enables: red, green, blue, clear, comp from bit 4 down to bit 0
`define LSMC_CH_LS 5'h0B
`define LSMC_CH_CS 5'h1F
`define LSMC_CH_OFF 5'h00

`define LSMC_SRST_TIME_MS 10
`define LSMC_CLK_KHZ 125000
`define LSMC_SRST_CYCLES (`LSMC_SRST_TIME_MS * `LSMC_CLK_KHZ)
`define LSMC_SRST_CNT_W 21

`endif

/* hw/lsmc_pkg.sv */
/*
  types of the light sensor main control block.
  assumes lsmc_defines.svh on the include path.
*/
package lsmc_pkg;
  `include "lsmc_defines.svh"

  typedef enum logic [3:0] {
    st_idle,
    st_dev,
    st_ack_a,
    st_reg,
    st_ack_r,
    st_wdata,
    st_ack_w,
    st_rdata,
    st_rack
  } lsmc_i2c_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } lsmc_wr_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } lsmc_rd_t;

  typedef struct packed {
    logic light_sleep_after_irq;
    logic light_channel_set_select;
    logic light_sensor_on;
  } lsmc_ctrl_t;
endpackage

/* hw/lsmc_i2c_slave.sv */
/*
  i2c target byte engine: start/stop detection, address match, register
  pointer with auto-increment, write and read strobes.
  assumes scl and sda arrive asynchronously and that the caller answers
  rd_data and refuse combinationally in the same cycle.
*/
`timescale 1ns/1ps
module lsmc_i2c_slave
  import lsmc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [7:0] rd_data,
  input wire logic refuse,
  output logic [7:0] rd_addr,
  output lsmc_wr_t cand,
  output lsmc_wr_t wr,
  output lsmc_rd_t rd
);
  logic [1:0] pins;
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;
  lsmc_i2c_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic [7:0] tx_q;
  logic oe_q;
  logic sda_o_q;
  logic rw_q;
  logic mack_q;
  lsmc_wr_t wr_q;
  lsmc_rd_t rd_q;

  assign pins = {scl_i, sda_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (reset) begin
          meta_q[gi] <= 1'b1;
          sync_q[gi] <= 1'b1;
          prev_q[gi] <= 1'b1;
        end else begin
          meta_q[gi] <= pins[gi];
          sync_q[gi] <= meta_q[gi];
          prev_q[gi] <= sync_q[gi];
        end
      end
    end
  endgenerate

  wire scl = sync_q[1];
  wire sda = sync_q[0];
  wire scl_rise = scl & ~prev_q[1];
  wire scl_fall = ~scl & prev_q[1];
  wire start_c = scl & prev_q[1] & prev_q[0] & ~sda;
  wire stop_c = scl & prev_q[1] & ~prev_q[0] & sda;
  wire byte_done = (cnt_q == 4'h8);
  wire addr_hit = (shift_q[7:1] == `LSMC_I2C_ADDR);
  wire rx_state = (state_q == st_dev) || (state_q == st_reg) ||
                  (state_q == st_wdata) || (state_q == st_rdata);
  wire load_read = scl_fall && (((state_q == st_ack_a) && rw_q) ||
                                ((state_q == st_rack) && mack_q));

  assign cand = {(state_q == st_wdata) && byte_done && scl_fall, ptr_q, shift_q};
  assign rd_addr = ptr_q;
  assign sda_o = sda_o_q;
  assign sda_oe = oe_q;
  assign wr = wr_q;
  assign rd = rd_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= st_idle;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      tx_q <= 8'h00;
      oe_q <= 1'b0;
      sda_o_q <= 1'b0;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q.valid <= 1'b0;
      rd_q.valid <= 1'b0;
      if (start_c) begin
        state_q <= st_dev;
        cnt_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (stop_c) begin
        state_q <= st_idle;
        oe_q <= 1'b0;
      end else if (scl_rise) begin
        if (state_q == st_rack) begin
          mack_q <= ~sda;
        end else if (rx_state) begin
          shift_q <= {shift_q[6:0], sda};
          cnt_q <= cnt_q + 4'h1;
        end
      end else if (load_read) begin
        tx_q <= rd_data;
        oe_q <= ~rd_data[7];
        cnt_q <= 4'h0;
        state_q <= st_rdata;
        rd_q <= {1'b1, ptr_q};
      end else if (scl_fall) begin
        case (state_q)
          st_dev: if (byte_done) begin
            cnt_q <= 4'h0;
            rw_q <= shift_q[0];
            state_q <= addr_hit ? st_ack_a : st_idle;
            oe_q <= addr_hit;
          end
          st_reg: if (byte_done) begin
            cnt_q <= 4'h0;
            ptr_q <= shift_q;
            state_q <= st_ack_r;
            oe_q <= 1'b1;
          end
          st_wdata: if (byte_done) begin
            cnt_q <= 4'h0;
            wr_q <= {1'b1, ptr_q, shift_q};
            // a refused byte is left unanswered and the transfer dropped
            state_q <= refuse ? st_idle : st_ack_w;
            oe_q <= ~refuse;
          end
          st_ack_a: begin
            oe_q <= 1'b0;
            state_q <= st_reg;
          end
          st_ack_r: begin
            oe_q <= 1'b0;
            state_q <= st_wdata;
          end
          st_ack_w: begin
            oe_q <= 1'b0;
            ptr_q <= ptr_q + 8'h01;
            state_q <= st_wdata;
          end
          st_rdata: if (byte_done) begin
            oe_q <= 1'b0;
            ptr_q <= ptr_q + 8'h01;
            state_q <= st_rack;
          end else begin
            tx_q <= {tx_q[6:0], 1'b0};
            oe_q <= ~tx_q[6];
          end
          st_rack: begin
            oe_q <= 1'b0;
            state_q <= st_idle;
          end
          default: state_q <= st_idle;
        endcase
      end
    end
  end
endmodule

/* hw/lsmc_main_ctrl.sv */
/*
  light sensor main control: the control register behind the i2c target,
  software reset sequencing, sleep after interrupt and channel selection.
  assumes the converter pulses ls_conv_done and ls_irq_event on mclk and
  that the i2c wire level is resolved outside from sda_o and sda_oe.
*/
// Operation
// - writing bit 7 of control starts software reset at once and is not acknowledged
// - software reset leaves the power-on flag in status cleared
// - bit 7 at zero, its default, never causes a software reset
// - bit 3 at zero keeps measuring after a light interrupt
// - bit 3 at one drops the enable when the measurement after interrupt ends
// - in that mode a status read turns the light sensor back on
`timescale 1ns/1ps
module lsmc_main_ctrl
  import lsmc_pkg::*;
#(
  parameter int SRST_CYCLES = `LSMC_SRST_CYCLES
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic ls_irq_event,
  input wire logic ls_conv_done,
  output logic [4:0] ls_chan_en,
  output logic ls_active,
  output logic srst_busy
);
  lsmc_wr_t cand;
  lsmc_wr_t wr;
  lsmc_rd_t rd;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] ctrl_byte;
  logic [7:0] status_byte;
  logic refuse;
  logic srst_q;
  logic [`LSMC_SRST_CNT_W-1:0] srst_cnt_q;
  lsmc_ctrl_t ctrl_q;
  logic sleep_pend_q;
  logic slept_q;
  logic ls_int_q;
  logic por_q;
  logic [4:0] chan_q;
  logic [4:0] chan_d;

  // the target sits in reset for the whole software reset window
  wire core_rst = reset | srst_q;

  lsmc_i2c_slave lsmc_i2c_slave_inst (
    .mclk(mclk),
    .reset(core_rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .rd_data(rd_data),
    .refuse(refuse),
    .rd_addr(rd_addr),
    .cand(cand),
    .wr(wr),
    .rd(rd)
  );

  wire wr_ctrl = wr.valid && (wr.addr == `LSMC_REG_CTRL);
  wire srst_req = wr_ctrl && wr.data[`LSMC_BIT_SRST];
  wire rd_status = rd.valid && (rd.addr == `LSMC_REG_STATUS0);
  wire sleep_now = sleep_pend_q && ls_conv_done && ctrl_q.light_sensor_on;
  wire wake_now = slept_q && rd_status;
  wire pend_set = ls_irq_event && ctrl_q.light_sleep_after_irq && ctrl_q.light_sensor_on;

  // decided before the acknowledge slot so the byte is left unanswered
  assign refuse = cand.valid && (cand.addr == `LSMC_REG_CTRL) &&
                  cand.data[`LSMC_BIT_SRST];

  // bit 7 is write-only and always reads back zero
  always_comb begin
    ctrl_byte = `LSMC_READ_ZERO;
    ctrl_byte[`LSMC_BIT_SAI] = ctrl_q.light_sleep_after_irq;
    ctrl_byte[`LSMC_BIT_MODE] = ctrl_q.light_channel_set_select;
    ctrl_byte[`LSMC_BIT_EN] = ctrl_q.light_sensor_on;
    status_byte = `LSMC_READ_ZERO;
    status_byte[`LSMC_ST_BIT_POR] = por_q;
    status_byte[`LSMC_ST_BIT_LSINT] = ls_int_q;
  end

  // unmapped addresses read zero; writes there are dropped
  assign rd_data = (rd_addr == `LSMC_REG_CTRL) ? ctrl_byte :
                   (rd_addr == `LSMC_REG_STATUS0) ? status_byte : `LSMC_READ_ZERO;

  // mode is only looked at while enabled
  assign chan_d = !(ctrl_q.light_sensor_on && !srst_q) ? `LSMC_CH_OFF :
                  ctrl_q.light_channel_set_select ? `LSMC_CH_CS :
                  `LSMC_CH_LS;

  always_ff @(posedge mclk) begin
    if (reset) begin
      srst_q <= 1'b0;
      srst_cnt_q <= '0;
    end else if (srst_req && !srst_q) begin
      srst_q <= 1'b1;
      srst_cnt_q <= '0;
    end else if (srst_q) begin
      // device stays deaf for the whole window the host is told to wait
      if (srst_cnt_q == `LSMC_SRST_CNT_W'(SRST_CYCLES - 1)) begin
        srst_q <= 1'b0;
      end else begin
        srst_cnt_q <= srst_cnt_q + `LSMC_SRST_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_q <= '0;
      sleep_pend_q <= 1'b0;
      slept_q <= 1'b0;
      ls_int_q <= 1'b0;
      por_q <= 1'b1;
    end else if (srst_q) begin
      ctrl_q <= '0;
      sleep_pend_q <= 1'b0;
      slept_q <= 1'b0;
      ls_int_q <= 1'b0;
      por_q <= 1'b0;
    end else begin
      // set beats the read clear so an interrupt on the read is kept
      if (ls_irq_event) begin
        ls_int_q <= 1'b1;
      end else if (rd_status) begin
        ls_int_q <= 1'b0;
      end
      if (rd_status) begin
        por_q <= 1'b0;
      end
      if (sleep_now) begin
        ctrl_q.light_sensor_on <= 1'b0;
        sleep_pend_q <= 1'b0;
        slept_q <= 1'b1;
      end else if (wake_now) begin
        ctrl_q.light_sensor_on <= 1'b1;
        slept_q <= 1'b0;
      end
      // a new interrupt beats the sleep that consumes the previous one
      if (pend_set) begin
        sleep_pend_q <= 1'b1;
      end
      // a host write wins over the sleep logic; a write with bit 7 set stores nothing
      if (wr_ctrl && !srst_req) begin
        ctrl_q.light_sleep_after_irq <= wr.data[`LSMC_BIT_SAI];
        ctrl_q.light_channel_set_select <= wr.data[`LSMC_BIT_MODE];
        ctrl_q.light_sensor_on <= wr.data[`LSMC_BIT_EN];
        sleep_pend_q <= 1'b0;
        slept_q <= 1'b0;
      end
    end
  end

  // registered so the converter sees one clean level per cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      chan_q <= `LSMC_CH_OFF;
    end else begin
      chan_q <= chan_d;
    end
  end

  assign ls_chan_en = chan_q;
  assign ls_active = ctrl_q.light_sensor_on;
  assign srst_busy = srst_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_srst_start: assert property (srst_req && !srst_q |=> srst_q)
    else $error("software reset did not start after control write");
  a_srst_nack: assert property (cand.valid && refuse |=> !sda_oe)
    else $error("software reset write was acknowledged");
  a_srst_deaf: assert property (srst_q |=> !sda_oe && !ctrl_q.light_sensor_on)
    else $error("bus answered or sensor on during software reset");
  a_srst_hold: assert property ($rose(srst_q) |-> srst_q [*8])
    else $error("software reset window ended too early");
  a_por_clear: assert property (srst_q |=> !por_q)
    else $error("power-on flag set after software reset");
  a_no_srst: assert property (wr_ctrl && !wr.data[`LSMC_BIT_SRST] && !srst_q
                              |=> !srst_q)
    else $error("software reset without bit 7");
  a_sai_keep: assert property (ctrl_q.light_sensor_on && !ctrl_q.light_sleep_after_irq
                               && !wr_ctrl && !srst_q |=> ctrl_q.light_sensor_on)
    else $error("enable dropped with sleep after interrupt off");
  a_int_flag: assert property (ls_irq_event && !srst_q |=> ls_int_q)
    else $error("light interrupt status not raised");
  a_sai_sleep: assert property (sleep_now && !wr_ctrl && !srst_q
                                |=> !ctrl_q.light_sensor_on && slept_q)
    else $error("enable kept after measurement with sleep pending");
  a_sai_wake: assert property (wake_now && !wr_ctrl && !srst_q
                               |=> ctrl_q.light_sensor_on)
    else $error("status read did not re-enable light sensor");
  a_ls_chans: assert property (ctrl_q.light_sensor_on && !srst_q &&
                               !ctrl_q.light_channel_set_select |=> ls_chan_en == `LSMC_CH_LS)
    else $error("wrong channel set in ambient mode");
  a_cs_chans: assert property (ctrl_q.light_sensor_on && !srst_q &&
                               ctrl_q.light_channel_set_select |=> ls_chan_en == `LSMC_CH_CS)
    else $error("wrong channel set in colour mode");
  a_off_idle: assert property (!ctrl_q.light_sensor_on |=> ls_chan_en == `LSMC_CH_OFF)
    else $error("channels active while light sensor off");
  a_off_stays: assert property (!ctrl_q.light_sensor_on && !slept_q && !wr_ctrl
                                |=> !ctrl_q.light_sensor_on)
    else $error("light sensor turned on without a write or a wake");
  a_wr_store: assert property (wr_ctrl && !srst_req && !srst_q
                               |=> ctrl_q.light_sensor_on == $past(wr.data[`LSMC_BIT_EN]))
    else $error("control write did not set the light sensor enable");
endmodule

/* test/lsmc_i2c_host.sv */
/*
  host side i2c master model: start, stop, bit and byte transfers and
  register access tasks called by the bench.
  assumes sda is the resolved wire level with a pull-up to one.
*/
`timescale 1ns/1ps
`include "lsmc_defines.svh"
module lsmc_i2c_host
  import lsmc_pkg::*;
(
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // six cycles a phase, above the three the synchronizer needs
  task automatic half();
    repeat (6) @(posedge mclk);
    #1;
  endtask

  // also serves as repeated start when entered with scl low
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask

  task automatic clk_bit(input logic drive_low, output logic got);
    sda_low = drive_low;
    half();
    scl = 1'b1;
    half();
    got = sda;
    scl = 1'b0;
  endtask

  task automatic tx(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(!d[i], b);
    end
    clk_bit(1'b0, b);
    ack = !b;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ack);
    logic k0;
    logic k1;
    start();
    tx({`LSMC_I2C_ADDR, 1'b0}, k0);
    tx(a, k1);
    // unused control bits always sent low
    tx((a == `LSMC_REG_CTRL) ? (d & 8'h8B) : d, ack);
    stop();
    ack = ack & k0 & k1;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    tx({`LSMC_I2C_ADDR, 1'b0}, k);
    tx(a, k);
    start();
    tx({`LSMC_I2C_ADDR, 1'b1}, k);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, d[i]);
    end
    // released line ends the read with a nack
    clk_bit(1'b0, k);
    stop();
  endtask
endmodule

/* test/light_sensor_main_control_bench.sv */
/*
  self-checking bench of the light sensor main control block.
  assumes the host model in lsmc_i2c_host.sv and a pulled-up sda wire.
*/
`timescale 1ns/1ps
`include "lsmc_defines.svh"
module light_sensor_main_control_bench
  import lsmc_pkg::*;
;
  localparam int SRST = 200;
  typedef struct packed {
    logic [7:0] wr;
    logic [4:0] chan;
    logic act;
  } lsmc_row_t;
  lsmc_row_t rows [6] = '{
    '{8'h00, 5'h00, 1'b0},
    '{8'h01, 5'h0B, 1'b1},
    '{8'h03, 5'h1F, 1'b1},
    '{8'h02, 5'h00, 1'b0},
    '{8'h09, 5'h0B, 1'b1},
    '{8'h0B, 5'h1F, 1'b1}
  };
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic irq = 1'b0;
  logic done = 1'b0;
  logic host_scl;
  logic host_low;
  logic sda_oe;
  logic sda_o;
  logic [4:0] ls_chan_en;
  logic ls_active;
  logic srst_busy;
  int miscompares = 0;
  int comparisons = 0;
  wire sda = !(host_low || sda_oe);

  always #4 mclk = ~mclk;

  lsmc_main_ctrl #(.SRST_CYCLES(SRST)) lsmc_main_ctrl_inst (
    .mclk(mclk), .reset(reset), .scl_i(host_scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .ls_irq_event(irq), .ls_conv_done(done), .ls_chan_en(ls_chan_en),
    .ls_active(ls_active), .srst_busy(srst_busy)
  );
  lsmc_i2c_host lsmc_i2c_host_inst (
    .mclk(mclk), .sda(sda), .scl(host_scl), .sda_low(host_low)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic exp_ack);
    logic ack;
    lsmc_i2c_host_inst.write_reg(a, d, ack);
    check({7'h00, ack}, {7'h00, exp_ack});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    lsmc_i2c_host_inst.read_reg(a, d);
    check(d, exp);
  endtask

  task automatic outs(input logic [4:0] chan, input logic act, input logic busy);
    repeat (3) @(posedge mclk);
    #1;
    // open-drain data value must never be driven high
    check({sda_o, srst_busy, ls_active, ls_chan_en}, {1'b0, busy, act, chan});
  endtask

  task automatic pulse(input logic sel);
    @(posedge mclk);
    #1;
    if (sel) begin
      done = 1'b1;
    end else begin
      irq = 1'b1;
    end
    @(posedge mclk);
    #1;
    done = 1'b0;
    irq = 1'b0;
  endtask

  initial begin
    int n;
    repeat (2) @(posedge mclk);
    #1;
    reset = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    outs(5'h00, 1'b0, 1'b0);
    rd(`LSMC_REG_STATUS0, 8'h80);
    rd(`LSMC_REG_STATUS0, 8'h00);
    foreach (rows[i]) begin
      wr(`LSMC_REG_CTRL, rows[i].wr, 1'b1);
      outs(rows[i].chan, rows[i].act, 1'b0);
      rd(`LSMC_REG_CTRL, rows[i].wr);
    end
    wr(`LSMC_REG_CTRL, 8'h01, 1'b1);
    pulse(1'b0);
    pulse(1'b1);
    outs(5'h0B, 1'b1, 1'b0);
    rd(`LSMC_REG_STATUS0, 8'h02);
    wr(`LSMC_REG_CTRL, 8'h0B, 1'b1);
    pulse(1'b0);
    // stays on until the running measurement ends
    outs(5'h1F, 1'b1, 1'b0);
    pulse(1'b1);
    outs(5'h00, 1'b0, 1'b0);
    rd(`LSMC_REG_STATUS0, 8'h02);
    outs(5'h1F, 1'b1, 1'b0);
    rd(`LSMC_REG_CTRL, 8'h0B);
    rd(8'h20, 8'h00);
    wr(`LSMC_REG_CTRL, 8'h83, 1'b0);
    outs(5'h00, 1'b0, 1'b1);
    n = 0;
    // sampled off the edge so the last busy cycle is counted once
    while (n < SRST + 50 && srst_busy !== 1'b0) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (srst_busy !== 1'b0) begin
      miscompares++;
      end_sim();
    end
    // the window began a few host phases before this wait
    check({7'h00, n >= SRST - 40}, 8'h01);
    repeat (5) @(posedge mclk);
    #1;
    rd(`LSMC_REG_STATUS0, 8'h00);
    rd(`LSMC_REG_CTRL, 8'h00);
    end_sim();
  end
endmodule
